// ===== sim/osw_src_model.sv
/*
  source selection model: answers a switch request after a set delay.
  assumes the request is a registered level on the system clock.
*/
`timescale 1ns/10ps
module osw_src_model (
  input  wire logic       clk_i,   // system clock
  input  wire logic       rst_i,   // sync reset, high
  input  wire logic       req_i,   // switch request
  input  wire logic [3:0] dly_i,   // cycles before answering
  output      logic       done_o   // switch finished
);
  logic [3:0] cnt_q;
  // count while requested, hold done, drop it once the request clears
  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i) begin
      cnt_q  <= 4'h0;
      done_o <= 1'b0;
    end else if (cnt_q == dly_i) begin
      done_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // osw_src_model

// ===== sim/osw_top_tb.sv
/*
  self-checking bench of the oscillator switch and fail flag block.
  assumes the source model answers switch requests.
*/
`timescale 1ns/10ps
module osw_top_tb;
  import osw_pkg::*;
  typedef struct packed {logic [7:0] adr; logic [31:0] exp;} osw_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic        fail  = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [31:0] wdat  = 32'h0;
  logic [3:0]  dly   = 4'hF;
  logic [31:0] rdat, dat_o;
  logic        ack, req, trap, irq, done;
  logic [2:0]  sel_o, cur_o;
  int          errors = 0;
  int          checked = 0;
  int          traps = 0;
  osw_row_t    rows [5] = '{'{8'h00, 32'h0}, '{8'h04, 32'h0}, '{8'h08, 32'h0},
                            '{8'h10, 32'h0}, '{8'h14, 32'h0}};

  osw_top i_osw_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .monitor_fail_i(fail), .switch_done_i(done), .switch_req_o(req),
    .osc_sel_o(sel_o), .cur_osc_o(cur_o), .osc_fail_trap_o(trap), .irq_o(irq));
  osw_src_model i_osw_src_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
    .dly_i(dly), .done_o(done));

  // clock and trap pulse counter
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) if (trap === 1'b1) traps <= traps + 1;

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // classic single cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    if (n >= 50) errors++;
    rdat = dat_o;
    cyc <= 1'b0; we <= 1'b0;
  endtask

  task unlock();
    wb(1'b1, OSW_KEY_OFS, {16'h0, OSW_KEY1_DEF});
    wb(1'b1, OSW_KEY_OFS, {16'h0, OSW_KEY2_DEF});
  endtask

  task wait_req_low();
    int n;
    n = 0;
    while (req !== 1'b0 && n < 60) begin @(posedge clk_i); n++; end
    chk(req, 1'b0);
  endtask

  task test_done();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #300000;
    errors++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values and an unmapped offset
    foreach (rows[i]) begin
      wb(1'b0, rows[i].adr, 32'h0);
      chk(rdat, rows[i].exp);
    end
    // locked write, then a broken key pair, both ignored
    wb(1'b1, OSW_CTRL_OFS, 32'h501);
    wb(1'b1, OSW_KEY_OFS, {16'h0, OSW_KEY1_DEF});
    wb(1'b1, OSW_EN_OFS, 32'h3);
    wb(1'b1, OSW_KEY_OFS, {16'h0, OSW_KEY2_DEF});
    wb(1'b1, OSW_CTRL_OFS, 32'h501);
    wb(1'b0, OSW_CTRL_OFS, 32'h0);
    chk(rdat, 32'h0);
    // slow switch to source 5, reserved bits written high
    unlock();
    wb(1'b1, OSW_CTRL_OFS, 32'h517);
    wb(1'b0, OSW_CTRL_OFS, 32'h0);
    chk(rdat, 32'h501);
    chk(sel_o, 3'h5);
    wait_req_low();
    wb(1'b0, OSW_CTRL_OFS, 32'h0);
    chk(rdat, 32'h5500);
    chk(irq, 1'b1);
    wb(1'b1, OSW_CLR_OFS, 32'h1);
    wb(1'b0, OSW_STS_OFS, 32'h0);
    chk(rdat, 32'h0);
    chk(irq, 1'b0);
    // prompt switch back to source 0, answered with no delay
    dly <= 4'h0;
    unlock();
    wb(1'b1, OSW_CTRL_OFS, 32'h001);
    wait_req_low();
    chk(cur_o, 3'h0);
    // monitor reports a failure
    fail <= 1'b1;
    repeat (5) @(posedge clk_i);
    chk(traps, 1);
    wb(1'b0, OSW_CTRL_OFS, 32'h0);
    chk(rdat, 32'h8);
    chk(irq, 1'b1);
    // software clears the flag while the pin stays high
    unlock();
    wb(1'b1, OSW_CTRL_OFS, 32'h0);
    wb(1'b0, OSW_CTRL_OFS, 32'h0);
    chk(rdat, 32'h0);
    fail <= 1'b0;
    wb(1'b1, OSW_CLR_OFS, 32'h3);
    wb(1'b0, OSW_STS_OFS, 32'h0);
    chk(irq, 1'b0);
    // software raised failure
    unlock();
    wb(1'b1, OSW_CTRL_OFS, 32'h8);
    wb(1'b0, OSW_STS_OFS, 32'h0);
    chk(rdat, 32'h2);
    chk(traps, 2);
    chk(irq, 1'b1);
    test_done();
  end
endmodule // osw_top_tb

// ===== src/osw_key_if.sv
/*
  carrier between the bus decoder and the unlock guard.
  assumes both ends sit on the same clock.
*/
`timescale 1ns/10ps
interface osw_key_if;
  logic        key_wr;    // write taken at the key register
  logic [15:0] key_data;  // data of that write
  logic        other_wr;  // any other write taken
  logic        granted;   // next write may reach the control register

  modport guard (input key_wr, key_data, other_wr, output granted);
  modport host  (output key_wr, key_data, other_wr, input granted);
endinterface

// ===== src/osw_pkg.sv
/*
  constants, types and register map of the oscillator switch and fail flag block.
  assumes a 32-bit classic wishbone master and a 10 MHz system clock.
*/
package osw_pkg;

  // register byte offsets
  localparam logic [7:0]  OSW_CTRL_OFS   = 8'h00;
  localparam logic [7:0]  OSW_KEY_OFS    = 8'h04;
  localparam logic [7:0]  OSW_STS_OFS    = 8'h08;
  localparam logic [7:0]  OSW_CLR_OFS    = 8'h0C;
  localparam logic [7:0]  OSW_EN_OFS     = 8'h10;

  // control register field positions
  localparam int          OSW_REQ_BIT    = 0;
  localparam int          OSW_CF_BIT     = 3;
  localparam int          OSW_NEXT_OSC_SELECT_LSB   = 8;
  localparam int          OSW_COSC_LSB   = 12;

  // status / clear / enable bit positions
  localparam int          OSW_EV_DONE    = 0;
  localparam int          OSW_EV_FAIL    = 1;

  // reset values
  localparam logic [2:0]  OSW_OSC_RST    = 3'h0;
  localparam logic [1:0]  OSW_EN_RST     = 2'h0;

  // unlock keys, values arbitrary
  localparam logic [15:0] OSW_KEY1_DEF   = 16'h5A3C;
  localparam logic [15:0] OSW_KEY2_DEF   = 16'hC3A5;

  typedef enum logic [1:0] {OSW_LOCKED, OSW_GOT_KEY1, OSW_OPEN} osw_ulk_t;

  // whole state of the top module
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic        req;
    logic [2:0]  next_osc_select;
    logic [2:0]  cosc;
    logic        cf;
    logic [1:0]  sts;
    logic [1:0]  en;
    logic        irq;
    logic        trap;
    logic        fail_s1;
    logic        fail_s2;
    logic        fail_s3;
    logic        done_s1;
    logic        done_s2;
  } osw_state_t;

endpackage

// ===== src/osw_top.sv
/*
  oscillator switch request and clock fail flag, reached over classic wishbone.
  assumes fail and switch-done inputs come from outside the clock domain.
*/
`timescale 1ns/10ps
module osw_top #(
  parameter logic [15:0] KEY1    = osw_pkg::OSW_KEY1_DEF,  // first unlock key
  parameter logic [15:0] KEY2    = osw_pkg::OSW_KEY2_DEF,  // second unlock key
  parameter logic [2:0]  OSC_RST = osw_pkg::OSW_OSC_RST    // source after reset
) (
  input  wire logic        clk_i,            // system clock, 10 MHz
  input  wire logic        rst_i,            // sync reset, high
  input  wire logic        wb_cyc_i,         // bus cycle
  input  wire logic        wb_stb_i,         // strobe
  input  wire logic        wb_we_i,          // write enable
  input  wire logic [7:0]  wb_adr_i,         // byte address
  input  wire logic [3:0]  wb_sel_i,         // byte lanes
  input  wire logic [31:0] wb_dat_i,         // write data
  output      logic [31:0] wb_dat_o,         // read data
  output      logic        wb_ack_o,         // acknowledge
  input  wire logic        monitor_fail_i,   // fail-safe clock monitor, async level
  input  wire logic        switch_done_i,    // source logic finished, async level
  output      logic        switch_req_o,     // switch request to source logic
  output      logic [2:0]  osc_sel_o,        // requested source
  output      logic [2:0]  cur_osc_o,        // active source
  output      logic        osc_fail_trap_o,  // trap pulse
  output      logic        irq_o             // level interrupt
);
  import osw_pkg::*;

  osw_state_t st_q, st_d;
  osw_key_if  kif ();

  logic take, wr, hit_ctrl, ctrl_ok, hw_fail_ev, sw_cf_set, sw_cf_clr, req_wr, sw_done;
  logic [31:0] rd;

  // bus decode, one answer per request
  assign take       = wb_cyc_i && wb_stb_i && !st_q.ack;
  assign wr         = take && wb_we_i;
  assign hit_ctrl   = (wb_adr_i == OSW_CTRL_OFS);
  assign ctrl_ok    = wr && hit_ctrl && kif.granted && wb_sel_i[0];
  assign hw_fail_ev = st_q.fail_s2 && !st_q.fail_s3;
  assign sw_cf_set  = ctrl_ok && wb_dat_i[OSW_CF_BIT] && !st_q.cf;
  assign sw_cf_clr  = ctrl_ok && !wb_dat_i[OSW_CF_BIT];
  assign req_wr     = ctrl_ok && wb_dat_i[OSW_REQ_BIT] && !st_q.req;
  assign sw_done    = st_q.req && st_q.done_s2;

  // guard strobes
  assign kif.key_wr   = wr && (wb_adr_i == OSW_KEY_OFS) && (&wb_sel_i[1:0]);
  assign kif.key_data = wb_dat_i[15:0];
  assign kif.other_wr = wr && !kif.key_wr;

  osw_unlock #(
    .KEY1 (KEY1),
    .KEY2 (KEY2)
  ) u_unlock (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .kif   (kif)
  );

  // read mux, unused bits zero
  always_comb begin
    rd = 32'h0000_0000;
    case (wb_adr_i)
      OSW_CTRL_OFS: begin
        rd[OSW_REQ_BIT]                   = st_q.req;
        rd[OSW_CF_BIT]                    = st_q.cf;
        rd[OSW_NEXT_OSC_SELECT_LSB +: 3]             = st_q.next_osc_select;
        rd[OSW_COSC_LSB +: 3]             = st_q.cosc;
      end
      OSW_STS_OFS: rd[1:0] = st_q.sts;
      OSW_EN_OFS:  rd[1:0] = st_q.en;
      default:     rd = 32'h0000_0000;
    endcase
  end

  // next state
  always_comb begin
    st_d         = st_q;
    st_d.ack     = take;
    st_d.dat     = (take && !wb_we_i) ? rd : 32'h0000_0000;
    st_d.fail_s1 = monitor_fail_i;
    st_d.fail_s2 = st_q.fail_s1;
    st_d.fail_s3 = st_q.fail_s2;
    st_d.done_s1 = switch_done_i;
    st_d.done_s2 = st_q.done_s1;
    // next select frozen while a switch is pending
    if (wr && hit_ctrl && kif.granted && wb_sel_i[1] && !st_q.req) begin
      st_d.next_osc_select = wb_dat_i[OSW_NEXT_OSC_SELECT_LSB +: 3];
    end
    // switch request and completion
    if (req_wr) begin
      st_d.req = 1'b1;
    end else if (sw_done) begin
      st_d.req  = 1'b0;
      st_d.cosc = st_q.next_osc_select;
    end
    // fail flag: set wins over clear
    if (hw_fail_ev || sw_cf_set) begin
      st_d.cf = 1'b1;
    end else if (sw_cf_clr) begin
      st_d.cf = 1'b0;
    end
    st_d.trap = st_d.cf && !st_q.cf;
    // interrupt status, enable, clear; set wins
    if (wr && wb_adr_i == OSW_EN_OFS && wb_sel_i[0]) begin
      st_d.en = wb_dat_i[1:0];
    end
    if (wr && wb_adr_i == OSW_CLR_OFS && wb_sel_i[0]) begin
      st_d.sts = st_q.sts & ~wb_dat_i[1:0];
    end
    if (sw_done) begin
      st_d.sts[OSW_EV_DONE] = 1'b1;
    end
    if (st_d.trap) begin
      st_d.sts[OSW_EV_FAIL] = 1'b1;
    end
    st_d.irq = |(st_d.sts & st_d.en);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q      <= '0;
      st_q.next_osc_select <= OSC_RST;
      st_q.cosc <= OSC_RST;
      st_q.en   <= OSW_EN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign wb_dat_o        = st_q.dat;
  assign wb_ack_o        = st_q.ack;
  assign switch_req_o    = st_q.req;
  assign osc_sel_o       = st_q.next_osc_select;
  assign cur_osc_o       = st_q.cosc;
  assign osc_fail_trap_o = st_q.trap;
  assign irq_o           = st_q.irq;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_done;
    st_q.req && st_q.done_s2;
  endsequence
  sequence s_sw_write_one;
    sw_cf_set;
  endsequence

  cf_set_a: assert property (hw_fail_ev |=> st_q.cf)
    else $error("fail flag not set by monitor");
  cf_cause_a: assert property ($rose(st_q.cf) |-> ($past(hw_fail_ev) || $past(sw_cf_set)))
    else $error("fail flag rose without cause");
  sw_trap_a: assert property (s_sw_write_one |=> st_q.cf && osc_fail_trap_o ##1 !osc_fail_trap_o)
    else $error("software fail set gave no single trap");
  req_start_a: assert property (req_wr |=> switch_req_o && osc_sel_o == $past(st_d.next_osc_select))
    else $error("switch request not raised");
  req_done_a: assert property (s_done |=> !st_q.req && cur_osc_o == $past(osc_sel_o))
    else $error("switch completion not reported");
  locked_wr_a: assert property (wr && hit_ctrl && !kif.granted
                                |=> $stable(osc_sel_o) && !$rose(st_q.req))
    else $error("locked control write took effect");
  zero_bits_a: assert property (take && !wb_we_i && hit_ctrl
                                |=> wb_ack_o && wb_dat_o[4] == 1'b0 && wb_dat_o[2:1] == 2'b00)
    else $error("unimplemented bits read nonzero");
  done_irq_a: assert property (s_done ##1 st_q.en[OSW_EV_DONE] |-> irq_o)
    else $error("switch done did not interrupt");
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

endmodule // osw_top

// ===== src/osw_unlock.sv
/*
  unlock guard: two key writes in a row open the control register for one write.
  assumes strobes are one-cycle pulses on the system clock.
*/
`timescale 1ns/10ps
module osw_unlock #(
  parameter logic [15:0] KEY1 = osw_pkg::OSW_KEY1_DEF,  // first key
  parameter logic [15:0] KEY2 = osw_pkg::OSW_KEY2_DEF   // second key
) (
  input  wire logic clk_i,  // system clock
  input  wire logic rst_i,  // sync reset, high
  osw_key_if.guard  kif     // strobes from the decoder
);
  import osw_pkg::*;

  typedef struct packed {
    osw_ulk_t stage;
  } osw_ulk_state_t;

  osw_ulk_state_t st_q, st_d;

  // key sequencer, any stray write relocks
  always_comb begin
    st_d = st_q;
    if (kif.key_wr) begin
      if (kif.key_data == KEY2 && st_q.stage == OSW_GOT_KEY1) begin
        st_d.stage = OSW_OPEN;
      end else if (kif.key_data == KEY1) begin
        st_d.stage = OSW_GOT_KEY1;
      end else begin
        st_d.stage = OSW_LOCKED;
      end
    end else if (kif.other_wr) begin
      st_d.stage = OSW_LOCKED;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q.stage <= OSW_LOCKED;
    end else begin
      st_q <= st_d;
    end
  end

  assign kif.granted = (st_q.stage == OSW_OPEN);

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_key1;
    kif.key_wr && kif.key_data == KEY1;
  endsequence
  sequence s_key2;
    kif.key_wr && kif.key_data == KEY2;
  endsequence

  key_pair_a: assert property (s_key1 ##1 (!kif.key_wr && !kif.other_wr) [*2] ##1 s_key2
                               |=> kif.granted)
    else $error("two keys did not open the guard");
  relock_a: assert property (kif.other_wr |=> !kif.granted)
    else $error("guard stayed open after a write");
  no_key_open_a: assert property (!kif.granted && !kif.key_wr |=> !kif.granted)
    else $error("guard opened without a key write");

endmodule // osw_unlock
